//--- rtl/hdlc_datalink_tx_rx.sv
/*
  hdlc data-link transmitter and receiver with a wishbone register port.
  assumes rx_line is synchronous to clk and one line bit per bit_div cycles.
*/
// The implementer's own choices: the Wishbone slave port and the register offsets.
`default_nettype none
module hdlc_datalink_tx_rx #(
  parameter int BIT_DIV = hdlc_datalink_pkg::BIT_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_line,
  output logic tx_line,
  output logic tx_link_service_req,
  output logic tx_link_exception,
  output logic rx_link_service_req,
  output logic rx_link_end_event,
  output logic shared_irq_n
);
  // bit rate enable
  logic [15:0] div_q;
  wire bit_tick = div_q == 16'(BIT_DIV - 1);

  // register bus decode
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i && wb_sel_i[0];
  wire rd = req && !wb_we_i;
  wire hit_txcfg = wb_adr_i == hdlc_datalink_pkg::OFF_TX_CFG;
  wire hit_txstat = wb_adr_i == hdlc_datalink_pkg::OFF_TX_STAT;
  wire hit_txdata = wb_adr_i == hdlc_datalink_pkg::OFF_TX_DATA;
  wire hit_rxcfg = wb_adr_i == hdlc_datalink_pkg::OFF_RX_CFG;
  wire hit_rxint = wb_adr_i == hdlc_datalink_pkg::OFF_RX_INT;
  wire hit_rxdata = wb_adr_i == hdlc_datalink_pkg::OFF_RX_DATA;
  wire hit_rxstat = wb_adr_i == hdlc_datalink_pkg::OFF_RX_STAT;
  wire hit_opt = wb_adr_i == hdlc_datalink_pkg::OFF_LINK_OPT;

  // control registers
  logic [3:0] tx_cfg_q;
  logic [5:0] opt_q;
  logic rx_en_q;
  logic [1:0] rx_lvl_q;
  wire tx_en = tx_cfg_q[hdlc_datalink_pkg::TXC_EN];
  wire crc_en = tx_cfg_q[hdlc_datalink_pkg::TXC_CRC];
  wire tx_tx_irq_enable = tx_cfg_q[hdlc_datalink_pkg::TXC_TX_IRQ_ENABLE];
  wire eom_q = tx_cfg_q[hdlc_datalink_pkg::TXC_EOM];
  wire rx_restart = wr && hit_rxcfg && wb_dat_i[hdlc_datalink_pkg::RXC_RESTART];

  // transmitter
  hdlc_datalink_pkg::tx_state_t tx_st_q, tx_st_d;
  logic [7:0] tx_sr_q, tx_sr_d, txd_q;
  logic [2:0] tx_bit_q, tx_bit_d, tx_ones_q, tx_ones_d;
  logic tx_hi_q, tx_hi_d, tx_line_d, txd_full_q, udr_q;
  logic tx_load, tx_close, tx_underrun;
  logic [15:0] tx_crc_q, tx_crc_next;
  wire tx_stuffing = tx_st_q == hdlc_datalink_pkg::TX_DATA || tx_st_q == hdlc_datalink_pkg::TX_FCS;
  wire tx_stuff = tx_ones_q == hdlc_datalink_pkg::ONES_STUFF;
  wire tx_shift = bit_tick && tx_en && tx_st_q != hdlc_datalink_pkg::TX_OFF && !tx_stuff;
  wire tx_int = tx_en && !txd_full_q;

  crc_ccitt u_tx_crc (
    .clk(clk),
    .rst_n(rst_n),
    .init(tx_load && tx_st_q == hdlc_datalink_pkg::TX_FLAG),
    .en(tx_shift && tx_st_q == hdlc_datalink_pkg::TX_DATA),
    .bit_in(tx_sr_q[0]),
    .crc_q(tx_crc_q),
    .crc_next(tx_crc_next)
  );

  always_comb
  begin
    tx_st_d = tx_st_q;
    tx_sr_d = tx_sr_q;
    tx_bit_d = tx_bit_q;
    tx_ones_d = tx_ones_q;
    tx_hi_d = tx_hi_q;
    tx_line_d = tx_line;
    tx_load = 1'b0;
    tx_close = 1'b0;
    tx_underrun = 1'b0;
    if (!tx_en)
    begin
      tx_st_d = hdlc_datalink_pkg::TX_OFF;
      tx_ones_d = 3'h0;
      tx_line_d = 1'b1;
    end
    else if (tx_st_q == hdlc_datalink_pkg::TX_OFF)
    begin
      tx_st_d = hdlc_datalink_pkg::TX_FLAG;
      tx_sr_d = hdlc_datalink_pkg::FLAG_SEQ;
      tx_bit_d = 3'h0;
    end
    else if (bit_tick && tx_stuff)
    begin
      tx_line_d = 1'b0;
      tx_ones_d = 3'h0;
    end
    else if (tx_shift)
    begin
      tx_line_d = tx_sr_q[0];
      tx_sr_d = {1'b0, tx_sr_q[7:1]};
      tx_bit_d = tx_bit_q + 3'h1;
      tx_ones_d = (tx_stuffing && tx_sr_q[0]) ? tx_ones_q + 3'h1 : 3'h0;
      if (tx_bit_q == hdlc_datalink_pkg::BIT_LAST)
      begin
        case (tx_st_q)
          hdlc_datalink_pkg::TX_FLAG, hdlc_datalink_pkg::TX_DATA:
          begin
            if (txd_full_q)
            begin
              tx_load = 1'b1;
              tx_sr_d = txd_q;
              tx_st_d = hdlc_datalink_pkg::TX_DATA;
            end
            else if (tx_st_q == hdlc_datalink_pkg::TX_FLAG)
              tx_sr_d = hdlc_datalink_pkg::FLAG_SEQ;
            else if (eom_q && crc_en)
            begin
              tx_sr_d = ~tx_crc_next[7:0];
              tx_st_d = hdlc_datalink_pkg::TX_FCS;
              tx_hi_d = 1'b0;
            end
            else if (eom_q)
            begin
              tx_close = 1'b1;
              tx_sr_d = hdlc_datalink_pkg::FLAG_SEQ;
              tx_st_d = hdlc_datalink_pkg::TX_FLAG;
            end
            else
            begin
              tx_underrun = 1'b1;
              tx_sr_d = hdlc_datalink_pkg::ABORT_SEQ;
              tx_st_d = hdlc_datalink_pkg::TX_ABORT;
            end
          end
          hdlc_datalink_pkg::TX_FCS:
          begin
            if (!tx_hi_q)
            begin
              tx_sr_d = ~tx_crc_q[15:8];
              tx_hi_d = 1'b1;
            end
            else
            begin
              tx_close = 1'b1;
              tx_sr_d = hdlc_datalink_pkg::FLAG_SEQ;
              tx_st_d = hdlc_datalink_pkg::TX_FLAG;
            end
          end
          hdlc_datalink_pkg::TX_ABORT:
          begin
            tx_sr_d = hdlc_datalink_pkg::FLAG_SEQ;
            tx_st_d = hdlc_datalink_pkg::TX_FLAG;
          end
          default:
            tx_st_d = hdlc_datalink_pkg::TX_FLAG;
        endcase
      end
    end
  end

  // receiver
  hdlc_datalink_pkg::rx_state_t rx_st_q;
  logic [7:0] rw_q, acc_q, pend_q;
  logic [6:0] dly_q;
  logic [2:0] r_ones_q, dcnt_q, acnt_q;
  logic pend_v_q, inf_q, ovr_q, end_q, avail_q;
  hdlc_datalink_pkg::rx_entry_t stat_q, head_q, push_e;
  logic [4:0] count_q;
  logic [15:0] rx_crc_q, rx_crc_next;
  wire rx_run = bit_tick && rx_en_q && !ovr_q;
  wire rx_active = rx_st_q == hdlc_datalink_pkg::RX_ACTIVE;
  wire [7:0] rw_n = {rx_line, rw_q[7:1]};
  wire flag_hit = rx_run && rw_n == hdlc_datalink_pkg::FLAG_SEQ;
  wire abort_hit = rx_run && rx_line && r_ones_q == hdlc_datalink_pkg::ONES_ABORT;
  wire stuffed = !rx_line && r_ones_q == hdlc_datalink_pkg::ONES_STUFF;
  wire real_bit = rx_run && rx_active && !flag_hit && !abort_hit && !stuffed
    && dcnt_q == hdlc_datalink_pkg::DLY_FULL;
  wire byte_done = real_bit && acnt_q == hdlc_datalink_pkg::BIT_LAST;
  wire [7:0] acc_n = {dly_q[0], acc_q[7:1]};
  wire end_push = (flag_hit || abort_hit) && rx_active && inf_q;
  wire dummy_push = flag_hit && !rx_active;
  wire push = (byte_done && pend_v_q) || end_push || dummy_push;
  wire overrun = push && count_q == hdlc_datalink_pkg::FIFO_DEPTH;
  wire rx_clear = flag_hit || abort_hit || rx_restart || !rx_en_q || overrun;
  wire pop = rd && hit_rxdata && avail_q;
  wire stat_rd = rd && hit_rxstat;
  wire [4:0] rx_lvl = {3'h0, rx_lvl_q} + 5'h01;
  wire rx_int = count_q >= rx_lvl;

  assign push_e.data = byte_done ? pend_q : ((pend_v_q && !dummy_push) ? pend_q : acc_q);
  assign push_e.end_of_message = !byte_done;
  assign push_e.flag_present = !abort_hit;
  assign push_e.crc_ok = flag_hit && rx_active && rx_crc_q == hdlc_datalink_pkg::CRC_GOOD;
  assign push_e.nvb = (end_push && !pend_v_q) ? acnt_q : 3'h0;

  crc_ccitt u_rx_crc (
    .clk(clk),
    .rst_n(rst_n),
    .init(flag_hit),
    .en(real_bit),
    .bit_in(dly_q[0]),
    .crc_q(rx_crc_q),
    .crc_next(rx_crc_next)
  );

  rx_fifo_mem u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(overrun),
    .push(push && !overrun),
    .wdata(push_e),
    .pop(pop),
    .rdata_q(head_q),
    .count_q(count_q)
  );

  // read data selection
  wire [7:0] rx_stat_v = {stat_q.nvb, stat_q.crc_ok, stat_q.end_of_message, stat_q.flag_present, ovr_q, !avail_q};
  wire [7:0] rd_val =
    hit_txcfg ? {4'h0, tx_cfg_q} :
    hit_txstat ? {6'h00, udr_q, tx_int} :
    hit_rxcfg ? {4'h0, rx_lvl_q, 1'b0, rx_en_q} :
    hit_rxint ? {7'h00, rx_int} :
    hit_rxdata ? (avail_q ? head_q.data : 8'h00) :
    hit_rxstat ? rx_stat_v :
    hit_opt ? {2'h0, opt_q} : 8'h00;
  wire irq_any = (tx_int && tx_tx_irq_enable && opt_q[hdlc_datalink_pkg::OPT_TX_REQ_IRQ])
    || (udr_q && opt_q[hdlc_datalink_pkg::OPT_TX_EXC_IRQ])
    || (rx_int && opt_q[hdlc_datalink_pkg::OPT_RX_REQ_IRQ]);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_q <= 16'h0000;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      tx_cfg_q <= hdlc_datalink_pkg::TX_CFG_RST;
      opt_q <= hdlc_datalink_pkg::LINK_OPT_RST;
      rx_en_q <= 1'b0;
      rx_lvl_q <= hdlc_datalink_pkg::RX_LVL_RST;
      shared_irq_n <= 1'b1;
    end
    else
    begin
      div_q <= bit_tick ? 16'h0000 : div_q + 16'h0001;
      wb_ack_o <= req;
      wb_dat_o <= rd ? {24'h00_0000, rd_val} : 32'h0000_0000;
      if (wr && hit_txcfg)
        tx_cfg_q <= wb_dat_i[3:0];
      else if (tx_close)
        tx_cfg_q[hdlc_datalink_pkg::TXC_EOM] <= 1'b0;
      if (wr && hit_opt)
        opt_q <= wb_dat_i[5:0];
      if (wr && hit_rxcfg)
      begin
        rx_en_q <= wb_dat_i[hdlc_datalink_pkg::RXC_EN];
        rx_lvl_q <= wb_dat_i[hdlc_datalink_pkg::RXC_LVL_LO +: 2];
      end
      shared_irq_n <= !irq_any;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_st_q <= hdlc_datalink_pkg::TX_OFF;
      tx_sr_q <= 8'hff;
      tx_bit_q <= 3'h0;
      tx_ones_q <= 3'h0;
      tx_hi_q <= 1'b0;
      tx_line <= 1'b1;
      txd_q <= 8'h00;
      txd_full_q <= 1'b0;
      udr_q <= 1'b0;
      tx_link_service_req <= 1'b0;
      tx_link_exception <= 1'b0;
    end
    else
    begin
      tx_st_q <= tx_st_d;
      tx_sr_q <= tx_sr_d;
      tx_bit_q <= tx_bit_d;
      tx_ones_q <= tx_ones_d;
      tx_hi_q <= tx_hi_d;
      tx_line <= tx_line_d;
      if (wr && hit_txdata)
        txd_q <= wb_dat_i[7:0];
      txd_full_q <= (wr && hit_txdata) || (txd_full_q && !tx_load && tx_en);
      udr_q <= tx_underrun || (udr_q && !(wr && hit_txstat
        && !wb_dat_i[hdlc_datalink_pkg::TXS_UDR]));
      tx_link_service_req <= tx_int && tx_tx_irq_enable;
      tx_link_exception <= tx_underrun || (udr_q && !(wr && hit_txstat
        && !wb_dat_i[hdlc_datalink_pkg::TXS_UDR]));
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_st_q <= hdlc_datalink_pkg::RX_HUNT;
      rw_q <= 8'hff;
      r_ones_q <= 3'h0;
      dly_q <= 7'h00;
      dcnt_q <= 3'h0;
      acc_q <= 8'h00;
      acnt_q <= 3'h0;
      pend_q <= 8'h00;
      pend_v_q <= 1'b0;
      inf_q <= 1'b0;
      ovr_q <= 1'b0;
      end_q <= 1'b0;
      avail_q <= 1'b0;
      stat_q <= '0;
      rx_link_service_req <= 1'b0;
      rx_link_end_event <= 1'b0;
    end
    else
    begin
      if (rx_run)
      begin
        rw_q <= rw_n;
        r_ones_q <= !rx_line ? 3'h0 : (r_ones_q == hdlc_datalink_pkg::ONES_MAX)
          ? r_ones_q : r_ones_q + 3'h1;
      end
      if (rx_run && !stuffed)
      begin
        dly_q <= {rx_line, dly_q[6:1]};
        dcnt_q <= (dcnt_q == hdlc_datalink_pkg::DLY_FULL) ? dcnt_q : dcnt_q + 3'h1;
      end
      if (real_bit)
      begin
        acc_q <= acc_n;
        acnt_q <= acnt_q + 3'h1;
        inf_q <= 1'b1;
      end
      if (byte_done)
      begin
        pend_q <= acc_n;
        pend_v_q <= 1'b1;
      end
      if (rx_clear)
      begin
        dcnt_q <= 3'h0;
        acnt_q <= 3'h0;
        pend_v_q <= 1'b0;
        inf_q <= 1'b0;
      end
      if (!rx_en_q || rx_restart || abort_hit || overrun)
        rx_st_q <= hdlc_datalink_pkg::RX_HUNT;
      else if (flag_hit)
        rx_st_q <= hdlc_datalink_pkg::RX_ACTIVE;
      if (!rx_en_q || rx_restart)
        rw_q <= 8'hff;
      ovr_q <= overrun || (ovr_q && !stat_rd);
      end_q <= overrun || (pop && head_q.end_of_message) || (end_q && !stat_rd);
      rx_link_end_event <= overrun || (pop && head_q.end_of_message) || (end_q && !stat_rd);
      avail_q <= count_q != 5'h00 && !pop && !overrun;
      if (pop)
        stat_q <= head_q;
      rx_link_service_req <= rx_en_q && rx_int;
    end
  end
endmodule : hdlc_datalink_tx_rx
`default_nettype wire

//--- rtl/hdlc_datalink_pkg.sv
/*
  constants, register map and types of the hdlc data-link transmitter and receiver.
  assumes a single 25 mhz clock and a classic wishbone slave port.
*/
`default_nettype none
package hdlc_datalink_pkg;
  localparam logic [7:0] OFF_TX_CFG = 8'h00;
  localparam logic [7:0] OFF_TX_STAT = 8'h04;
  localparam logic [7:0] OFF_TX_DATA = 8'h08;
  localparam logic [7:0] OFF_RX_CFG = 8'h0c;
  localparam logic [7:0] OFF_RX_INT = 8'h10;
  localparam logic [7:0] OFF_RX_DATA = 8'h14;
  localparam logic [7:0] OFF_RX_STAT = 8'h18;
  localparam logic [7:0] OFF_LINK_OPT = 8'h1c;
  // transmit configuration bits
  localparam int TXC_EN = 0;
  localparam int TXC_CRC = 1;
  localparam int TXC_TX_IRQ_ENABLE = 2;
  localparam int TXC_EOM = 3;
  // transmit status bits
  localparam int TXS_INT = 0;
  localparam int TXS_UDR = 1;
  // receive configuration bits
  localparam int RXC_EN = 0;
  localparam int RXC_RESTART = 1;
  localparam int RXC_LVL_LO = 2;
  // receive status bits
  localparam int RXS_FE = 0;
  localparam int RXS_OVR = 1;
  localparam int RXS_FLG = 2;
  localparam int RXS_EOM = 3;
  localparam int RXS_CRC = 4;
  localparam int RXS_NVB_LO = 5;
  // link option bits
  localparam int OPT_TX_DMA = 0;
  localparam int OPT_TX_FRAC = 1;
  localparam int OPT_TX_REQ_IRQ = 2;
  localparam int OPT_TX_EXC_IRQ = 3;
  localparam int OPT_RX_REQ_IRQ = 4;
  localparam int OPT_RX_DMA = 5;
  localparam logic [3:0] TX_CFG_RST = 4'h0;
  localparam logic [5:0] LINK_OPT_RST = 6'h00;
  localparam logic [1:0] RX_LVL_RST = 2'h0;
  localparam logic [7:0] FLAG_SEQ = 8'h7e;
  localparam logic [7:0] ABORT_SEQ = 8'hfe;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hf0b8;
  localparam logic [2:0] ONES_STUFF = 3'h5;
  localparam logic [2:0] ONES_ABORT = 3'h6;
  localparam logic [2:0] ONES_MAX = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] DLY_FULL = 3'h7;
  localparam int FIFO_AW = 4;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam int BIT_DIV_DEFAULT = 6250;
  typedef struct packed {
    logic [7:0] data;
    logic end_of_message;
    logic flag_present;
    logic crc_ok;
    logic [2:0] nvb;
  } rx_entry_t;
  typedef enum logic [2:0] {TX_OFF, TX_FLAG, TX_DATA, TX_FCS, TX_ABORT} tx_state_t;
  typedef enum logic {RX_HUNT, RX_ACTIVE} rx_state_t;
endpackage : hdlc_datalink_pkg
`default_nettype wire

//--- rtl/crc_ccitt.sv
/*
  bit-serial crc-ccitt, reflected, one bit per enable.
  assumes bits arrive first bit first and init has priority.
*/
`default_nettype none
module crc_ccitt (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic init,
  input wire logic en,
  input wire logic bit_in,
  output logic [15:0] crc_q,
  output logic [15:0] crc_next
);
  assign crc_next = {1'b0, crc_q[15:1]} ^
    ((crc_q[0] ^ bit_in) ? hdlc_datalink_pkg::CRC_POLY : 16'h0000);

  always_ff @(posedge clk)
  begin
    if (!rst_n || init)
      crc_q <= hdlc_datalink_pkg::CRC_INIT;
    else if (en)
      crc_q <= crc_next;
  end
endmodule : crc_ccitt
`default_nettype wire

//--- rtl/rx_fifo_mem.sv
/*
  receive fifo storage with registered head read data.
  assumes the user never pushes when full; head data lags a write by one cycle.
*/
`default_nettype none
module rx_fifo_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic push,
  input wire hdlc_datalink_pkg::rx_entry_t wdata,
  input wire logic pop,
  output hdlc_datalink_pkg::rx_entry_t rdata_q,
  output logic [4:0] count_q
);
  hdlc_datalink_pkg::rx_entry_t mem [2**hdlc_datalink_pkg::FIFO_AW];
  logic [hdlc_datalink_pkg::FIFO_AW-1:0] wptr_q;
  logic [hdlc_datalink_pkg::FIFO_AW-1:0] rptr_q;
  wire do_push = push && count_q != hdlc_datalink_pkg::FIFO_DEPTH;
  wire do_pop = pop && count_q != 5'h00;

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wptr_q] <= wdata;
    rdata_q <= mem[rptr_q];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || flush)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= 5'h00;
    end
    else
    begin
      wptr_q <= wptr_q + {3'h0, do_push};
      rptr_q <= rptr_q + {3'h0, do_pop};
      count_q <= count_q + {4'h0, do_push} - {4'h0, do_pop};
    end
  end
endmodule : rx_fifo_mem
`default_nettype wire

//--- sim/line_far_end.sv
/*
  far end of the serial data link: loops the sent stream back to the receiver.
  assumes the block's clock; the line idles at all ones when not looped.
*/
`default_nettype none
module line_far_end (
  input wire logic clk,
  input wire logic loop_en,
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // bit order kept as sent; idle link is all ones
  always_ff @(posedge clk)
    rx_line <= loop_en ? tx_line : 1'b1;
endmodule : line_far_end
`default_nettype wire

//--- sim/hdlc_datalink_properties.sv
/*
  port assertions of the data-link block.
  assumes one clock and a synchronous active-low reset.
*/
`default_nettype none
module hdlc_datalink_checker #(
  parameter int BIT_DIV = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tx_line,
  input wire logic tx_link_service_req,
  input wire logic tx_link_exception,
  input wire logic rx_link_service_req,
  input wire logic rx_link_end_event,
  input wire logic shared_irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tx_prev_q;
  int run_q;
  // cycles since the line last changed
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_prev_q <= 1'b1;
      run_q <= BIT_DIV;
    end
    else
    begin
      tx_prev_q <= tx_line;
      run_q <= (tx_line != tx_prev_q) ? 1 : ((run_q < BIT_DIV) ? run_q + 1 : run_q);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  dat_upper_a: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  irq_cause_a: assert property ($fell(shared_irq_n) |->
    tx_link_service_req || tx_link_exception || rx_link_service_req)
    else $error("shared irq without source");
  exc_clear_a: assert property ($fell(tx_link_exception) |->
    $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2))
    else $error("exception dropped without write");
  req_fall_a: assert property ($fell(tx_link_service_req) |->
    $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2))
    else $error("tx request dropped without write");
  end_clear_a: assert property ($fell(rx_link_end_event) |->
    $past(wb_cyc_i && !wb_we_i) || $past(wb_cyc_i && !wb_we_i, 2))
    else $error("end event dropped without read");
  bit_hold_a: assert property (tx_line != tx_prev_q |-> run_q >= BIT_DIV)
    else $error("tx bit shorter than a bit period");
  cover property (tx_link_exception);
  cover property (rx_link_end_event);
  cover property (!shared_irq_n);
endmodule : hdlc_datalink_checker
bind hdlc_datalink_tx_rx hdlc_datalink_checker #(.BIT_DIV(BIT_DIV)) checker_inst (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_line(tx_line),
  .tx_link_service_req(tx_link_service_req), .tx_link_exception(tx_link_exception),
  .rx_link_service_req(rx_link_service_req), .rx_link_end_event(rx_link_end_event),
  .shared_irq_n(shared_irq_n));
`default_nettype wire

//--- sim/tb.sv
/*
  self-checking bench: wishbone host, looped line, frame model with a queue.
  assumes the far end model and the bound checker.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_DIV = 4;
  logic clk, rst_n, cyc, stb, we, ack, loop_en, rx_line, tx_line;
  logic tx_req, tx_exc, rx_req, rx_end, irq_n;
  logic [7:0] adr, d, s;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, seed;
  logic [7:0] exp_q[$];
  int num_errors, num_checks, n, i;
  hdlc_datalink_tx_rx #(.BIT_DIV(BIT_DIV)) dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_line(rx_line), .tx_line(tx_line), .tx_link_service_req(tx_req),
    .tx_link_exception(tx_exc), .rx_link_service_req(rx_req),
    .rx_link_end_event(rx_end), .shared_irq_n(irq_n));
  line_far_end far (.clk(clk), .loop_en(loop_en), .tx_line(tx_line), .rx_line(rx_line));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic end_of_test;
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_pin(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: pin %b expected %b", $time, got, exp);
    end
  endtask : chk_pin
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    for (int k = 0; k < 8; k++)
      c = (c[0] ^ b[k]) ? ((c >> 1) ^ hdlc_datalink_pkg::CRC_POLY) : (c >> 1);
    return c;
  endfunction : crc_byte
  // one classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v,
                    input logic [3:0] m, output logic [7:0] q);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, v};
    sel <= m;
    @(posedge clk);
    for (k = 0; k < 50 && ack !== 1'b1; k++) @(posedge clk);
    q = rdat[7:0];
    chk_pin(ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic pop(output logic [7:0] dd, output logic [7:0] ss);
    int k;
    for (k = 0; k < 400 && rx_req !== 1'b1; k++) @(posedge clk);
    chk_pin(rx_req, 1'b1);
    wb(1'b0, 8'h14, 8'h00, 4'hf, dd);
    wb(1'b0, 8'h18, 8'h00, 4'hf, ss);
  endtask : pop
  task automatic send_frame(input int len, input logic crc, input int mid);
    int k, j;
    logic [7:0] q;
    logic [15:0] c;
    c = hdlc_datalink_pkg::CRC_INIT;
    wb(1'b1, 8'h00, {5'h0, 1'b1, crc, 1'b1}, 4'hf, q);
    for (k = 0; k < len; k++)
    begin
      for (j = 0; j < 400 && tx_req !== 1'b1; j++) @(posedge clk);
      chk_pin(tx_req, 1'b1);
      seed = lfsr(seed);
      q = (k < 2) ? ((k == 0) ? 8'hff : 8'h7e) : seed[7:0];
      exp_q.push_back(q);
      c = crc_byte(c, q);
      wb(1'b1, 8'h08, q, 4'hf, q);
      if (k == mid)
        chk_pin(irq_n, 1'b0);
    end
    for (j = 0; j < 400 && tx_req !== 1'b1; j++) @(posedge clk);
    chk_pin(tx_req, 1'b1);
    wb(1'b1, 8'h00, {4'h0, 1'b1, 1'b0, crc, 1'b1}, 4'hf, q);
    chk_pin(tx_req, 1'b0);
    c = ~c;
    if (crc)
    begin
      exp_q.push_back(c[7:0]);
      exp_q.push_back(c[15:8]);
    end
  endtask : send_frame
  task automatic check_frame(input logic crc);
    logic [7:0] dd, ss;
    for (int k = 0; k < 24; k++)
    begin
      pop(dd, ss);
      chk_byte(dd, exp_q.pop_front());
      if (ss[3])
        break;
    end
    chk_byte(ss & (crc ? 8'hff : 8'hef), crc ? 8'h1d : 8'h0d);
    chk_byte(8'(exp_q.size()), 8'h00);
  endtask : check_frame
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    $display("Error at %0t: timeout", $time);
    end_of_test;
  end
  initial
  begin
    {rst_n, cyc, stb, we, loop_en, adr, sel, wdat} = '0;
    seed = 32'h15cfd70b;
    num_errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 9; i++)
    begin
      wb(1'b0, (i == 8) ? 8'hfc : 8'(i * 4), 8'h00, 4'hf, d);
      chk_byte(d, (i == 6) ? 8'h01 : 8'h00);
    end
    wb(1'b1, 8'h00, 8'h01, 4'he, d);
    wb(1'b0, 8'h00, 8'h00, 4'hf, d);
    chk_byte(d, 8'h00);
    chk_pin(tx_line, 1'b1);
    loop_en <= 1'b1;
    wb(1'b1, 8'h00, 8'h01, 4'hf, d);
    wb(1'b1, 8'h0c, 8'h01, 4'hf, d);
    pop(d, s);
    chk_byte(s & 8'h0c, 8'h0c);
    wb(1'b1, 8'h0c, 8'h03, 4'hf, d);
    pop(d, s);
    chk_byte(s & 8'h0d, 8'h0d);
    send_frame(6, 1'b1, -1);
    check_frame(1'b1);
    send_frame(3, 1'b0, -1);
    check_frame(1'b0);
    wb(1'b1, 8'h1c, 8'h08, 4'hf, d);
    wb(1'b1, 8'h00, 8'h05, 4'hf, d);
    for (n = 0; n < 400 && tx_req !== 1'b1; n++) @(posedge clk);
    chk_pin(tx_req, 1'b1);
    seed = lfsr(seed);
    exp_q.push_back(seed[7:0]);
    wb(1'b1, 8'h08, seed[7:0], 4'hf, d);
    for (n = 0; n < 400 && tx_exc !== 1'b1; n++) @(posedge clk);
    chk_pin(tx_exc, 1'b1);
    repeat (2) @(posedge clk);
    chk_pin(irq_n, 1'b0);
    wb(1'b0, 8'h04, 8'h00, 4'hf, d);
    chk_byte(d & 8'h02, 8'h02);
    pop(d, s);
    chk_byte(d, exp_q.pop_front());
    chk_byte(s & 8'h0c, 8'h08);
    wb(1'b1, 8'h04, 8'h00, 4'hf, d);
    wb(1'b0, 8'h04, 8'h00, 4'hf, d);
    chk_byte(d & 8'h02, 8'h00);
    chk_pin(tx_exc, 1'b0);
    wb(1'b1, 8'h1c, 8'h04, 4'hf, d);
    repeat (3) @(posedge clk);
    chk_pin(irq_n, 1'b0);
    wb(1'b1, 8'h00, 8'h01, 4'hf, d);
    repeat (200) @(posedge clk);
    for (n = 0; n < 8 && rx_req === 1'b1; n++) pop(d, s);
    wb(1'b1, 8'h0c, 8'h0c, 4'hf, d);
    wb(1'b1, 8'h1c, 8'h10, 4'hf, d);
    wb(1'b1, 8'h0c, 8'h0d, 4'hf, d);
    repeat (200) @(posedge clk);
    chk_pin(rx_req, 1'b0);
    send_frame(20, 1'b1, 8);
    for (n = 0; n < 400 && rx_end !== 1'b1; n++) @(posedge clk);
    chk_pin(rx_end, 1'b1);
    wb(1'b0, 8'h18, 8'h00, 4'hf, s);
    chk_byte(s & 8'h02, 8'h02);
    repeat (2) @(posedge clk);
    chk_pin(rx_end, 1'b0);
    end_of_test;
  end
endmodule : tb
`default_nettype wire
